// ### design/ascp_defs.vh
// Constants for the converter serial configuration port.
// Assumes inclusion by bare name from the design files.
`ifndef ASCP_DEFS_VH
`define ASCP_DEFS_VH

// Configuration word layout, first received bit lands in bit 7
`define ASCP_CFG_BITS 5'h08
`define ASCP_CFG_MUX_HI 7
`define ASCP_CFG_MUX_LO 4
`define ASCP_CFG_UNI 3
`define ASCP_CFG_ORDER 2
`define ASCP_CFG_LEN_HI 1
`define ASCP_CFG_LEN_LO 0

// Output word lengths per length select code
`define ASCP_LEN_SEL_8 2'h0
`define ASCP_LEN_SEL_10 2'h1
`define ASCP_LEN_SEL_12 2'h2
`define ASCP_LEN_SEL_16 2'h3
`define ASCP_LEN_8 5'h08
`define ASCP_LEN_10 5'h0A
`define ASCP_LEN_12 5'h0C
`define ASCP_LEN_16 5'h10

// Result width and stored word layout
`define ASCP_RES_BITS 5'h0A
`define ASCP_RES_MSB 9
`define ASCP_WORD_UNI 10
`define ASCP_WORD_ORDER 11
`define ASCP_WORD_W 12

// Chip select recognition: conversion clock falls to wait
`define ASCP_CS_FALLS 2'h2

// Default conversion time in conversion clock cycles
`define ASCP_CONV_ACLK 8'h2C

// Reset values
`define ASCP_RESET_WORD 12'h000
`define ASCP_RESET_CFG 8'h00
// Synchroniser reset: select pin idles high, others low
`define ASCP_SYNC_RST 4'h8

`endif

// ### design/ascp_sync.v
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is an unrelated asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module ascp_sync #(
   parameter W = 4,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         stage1 <= RST;
         stage2 <= RST;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
      end
   end

   assign o_sync = stage2;
endmodule // ascp_sync
`default_nettype wire

// ### design/ascp_fifo.v
// Result FIFO with registered read data.
// Assumes one clock; read data appear the cycle after a pop.
`timescale 1ns/1ps
`default_nettype none
module ascp_fifo #(
   parameter W = 12,
   parameter D = 8,
   parameter AW = 3
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_wr_valid,
   output wire o_wr_ready,
   input wire [W-1:0] i_wr_data,
   output wire o_rd_valid,
   input wire i_rd_ready,
   output reg [W-1:0] o_rd_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign o_wr_ready = (count != D[AW:0]);
   assign o_rd_valid = (count != {(AW+1){1'b0}});
   assign push = i_wr_valid && o_wr_ready;
   assign pop = i_rd_ready && o_rd_valid;

   always @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_wr_data;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         o_rd_data <= {W{1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               wr_ptr + 1'b1;
         end
         if (pop) begin
            o_rd_data <= mem[rd_ptr];
            rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // ascp_fifo
`default_nettype wire

// ### design/ascp_port.v
// Serial configuration and result port of a 10-bit converter.
// Assumes asynchronous pins; the analog core supplies an offset code.
//
// Summary of operation
// - Bipolar results leave in two's complement
// - Sixth config bit one selects MSB first
// - Order bit applies to the next result
// - Config word always received in fixed order
// - Last two bits pick 8/10/12/16 length
// - Length bits apply to the current word
// - Select glitches under one period ignored
// - Select recognised after two conversion clock falls
// - Same filtering for both select edges
// - Output undriven until low select recognised
// - Shift clock ignored while deselected
// - Select held low: output after conversion
// - MSB first twelve bits: result, two zeros
// - Output on falling, input on rising edge
// - Capture first eight bits, ignore rest
// - Convert after exchange, return next cycle
// - Mux bits first four, fifth unipolar
`include "ascp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module ascp_port #(
   parameter CONV_ACLK = `ASCP_CONV_ACLK,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_din,
   input wire i_aclk,
   input wire [9:0] i_conv_code,
   output wire o_dout,
   output wire o_dout_oe,
   output reg o_conv_start,
   output reg o_conv_busy,
   output reg [3:0] o_conv_mux,
   output reg o_conv_unipolar,
   output wire o_cs_active
);
   localparam ST_IDLE = 3'h0;
   localparam ST_LOAD = 3'h1;
   localparam ST_FETCH = 3'h2;
   localparam ST_SHIFT = 3'h3;
   localparam ST_DONE = 3'h4;

   wire [3:0] pins_sync;
   wire cs_s;
   wire sclk_s;
   wire din_s;
   wire aclk_s;
   reg sclk_prev;
   reg aclk_prev;
   wire sclk_rise;
   wire sclk_fall;
   wire aclk_fall;

   reg cs_rec;
   reg [1:0] cs_falls;

   reg [2:0] st;
   reg [4:0] bit_cnt;
   reg [7:0] cfg;
   wire [7:0] cfg_now;
   reg [4:0] len;
   reg [11:0] out_word;
   reg dout;
   wire [4:0] len_now;
   wire end_hit;
   wire start_now;

   reg conv_order;
   reg [7:0] conv_cnt;
   reg conv_ready;
   reg [11:0] conv_word;

   wire fifo_wr_ready;
   wire fifo_rd_valid;
   wire fifo_pop;
   wire [11:0] fifo_rd_data;

   function [4:0] len_of;
      input [1:0] sel;
      begin
         case (sel)
            `ASCP_LEN_SEL_8: len_of = `ASCP_LEN_8;
            `ASCP_LEN_SEL_10: len_of = `ASCP_LEN_10;
            `ASCP_LEN_SEL_12: len_of = `ASCP_LEN_12;
            default: len_of = `ASCP_LEN_16;
         endcase
      end
   endfunction

   // Serial bit at a given position of a stored result word
   function out_bit;
      input [11:0] word;
      input [4:0] idx;
      reg [3:0] pos;
      begin
         pos = idx[3:0];
         if (idx >= `ASCP_RES_BITS) begin
            if (word[`ASCP_WORD_ORDER] || word[`ASCP_WORD_UNI]) begin
               out_bit = 1'b0;
            end else begin
               out_bit = word[`ASCP_RES_MSB];
            end
         end else if (word[`ASCP_WORD_ORDER]) begin
            out_bit = word[4'h9 - pos];
         end else begin
            out_bit = word[pos];
         end
      end
   endfunction

   ascp_sync #(
      .W(4),
      .RST(`ASCP_SYNC_RST)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async({i_cs_n, i_sclk, i_din, i_aclk}),
      .o_sync(pins_sync)
   );

   assign cs_s = pins_sync[3];
   assign sclk_s = pins_sync[2];
   assign din_s = pins_sync[1];
   assign aclk_s = pins_sync[0];
   assign sclk_rise = sclk_s && !sclk_prev;
   assign sclk_fall = !sclk_s && sclk_prev;
   assign aclk_fall = !aclk_s && aclk_prev;

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         sclk_prev <= 1'b0;
         aclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
         aclk_prev <= aclk_s;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         cs_rec <= 1'b1;
         cs_falls <= 2'h0;
      end else if (cs_s == cs_rec) begin
         cs_falls <= 2'h0;
      end else if (aclk_fall) begin
         if (cs_falls == `ASCP_CS_FALLS - 2'h1) begin
            cs_rec <= cs_s;
            cs_falls <= 2'h0;
         end else begin
            cs_falls <= cs_falls + 2'h1;
         end
      end
   end

   assign o_cs_active = !cs_rec;

   // Length known at eighth rising edge
   assign len_now = (bit_cnt == `ASCP_CFG_BITS - 5'h01) ?
      len_of({cfg[0], din_s}) : len;
   assign end_hit = (bit_cnt + 5'h01 == len_now);
   // Config as it stands after this rise
   assign cfg_now = (bit_cnt < `ASCP_CFG_BITS) ? {cfg[6:0], din_s} : cfg;
   assign start_now = (st == ST_SHIFT) && !cs_rec && sclk_rise && end_hit;
   assign fifo_pop = (st == ST_LOAD) && !cs_rec;

   assign o_dout_oe = (st == ST_SHIFT);
   assign o_dout = dout;

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         st <= ST_IDLE;
         bit_cnt <= 5'h00;
         cfg <= `ASCP_RESET_CFG;
         len <= `ASCP_LEN_8;
         out_word <= `ASCP_RESET_WORD;
         dout <= 1'b0;
      end else if (cs_rec) begin
         st <= ST_IDLE;
         bit_cnt <= 5'h00;
      end else begin
         case (st)
            ST_IDLE: begin
               st <= ST_LOAD;
            end
            ST_LOAD: begin
               if (fifo_rd_valid) begin
                  st <= ST_FETCH;
               end else if (!o_conv_busy) begin
                  st <= ST_SHIFT;
                  bit_cnt <= 5'h00;
                  dout <= out_bit(out_word, 5'h00);
               end
            end
            ST_FETCH: begin
               out_word <= fifo_rd_data;
               st <= ST_SHIFT;
               bit_cnt <= 5'h00;
               dout <= out_bit(fifo_rd_data, 5'h00);
            end
            ST_SHIFT: begin
               // Sample on rise, change on fall
               if (sclk_rise) begin
                  if (bit_cnt < `ASCP_CFG_BITS) begin
                     cfg <= {cfg[6:0], din_s};
                  end
                  if (bit_cnt == `ASCP_CFG_BITS - 5'h01) begin
                     len <= len_now;
                  end
                  bit_cnt <= bit_cnt + 5'h01;
                  if (end_hit) begin
                     st <= ST_DONE;
                  end
               end else if (sclk_fall) begin
                  dout <= out_bit(out_word, bit_cnt);
               end
            end
            ST_DONE: begin
               // Select held low: reload after conversion
               if (!o_conv_busy) begin
                  st <= ST_LOAD;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_conv_start <= 1'b0;
         o_conv_busy <= 1'b0;
         o_conv_mux <= 4'h0;
         o_conv_unipolar <= 1'b0;
         conv_order <= 1'b0;
         conv_cnt <= 8'h00;
         conv_ready <= 1'b0;
         conv_word <= `ASCP_RESET_WORD;
      end else begin
         o_conv_start <= 1'b0;
         if (start_now && !o_conv_busy) begin
            o_conv_start <= 1'b1;
            o_conv_busy <= 1'b1;
            o_conv_mux <= cfg_now[`ASCP_CFG_MUX_HI:`ASCP_CFG_MUX_LO];
            o_conv_unipolar <= cfg_now[`ASCP_CFG_UNI];
            // Order kept for the next word
            conv_order <= cfg_now[`ASCP_CFG_ORDER];
            conv_cnt <= 8'h00;
         end else if (o_conv_busy && !conv_ready && aclk_fall) begin
            if (conv_cnt == CONV_ACLK - 1) begin
               conv_ready <= 1'b1;
               conv_word <= {conv_order, o_conv_unipolar,
                  o_conv_unipolar ? i_conv_code :
                  {~i_conv_code[9], i_conv_code[8:0]}};
            end else begin
               conv_cnt <= conv_cnt + 8'h01;
            end
         end else if (conv_ready && fifo_wr_ready) begin
            conv_ready <= 1'b0;
            o_conv_busy <= 1'b0;
         end
      end
   end

   ascp_fifo #(
      .W(`ASCP_WORD_W),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr_valid(conv_ready),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(conv_word),
      .o_rd_valid(fifo_rd_valid),
      .i_rd_ready(fifo_pop),
      .o_rd_data(fifo_rd_data)
   );
endmodule // ascp_port
`default_nettype wire

// ### tb/ascp_port_checker.sv
// Checker: assertions on the serial port's top-level pins.
// Assumes a bind to ascp_port; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ascp_port_checker (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire i_sclk,
   input wire o_dout,
   input wire o_dout_oe,
   input wire o_conv_start,
   input wire o_conv_busy,
   input wire [3:0] o_conv_mux,
   input wire o_conv_unipolar,
   input wire o_cs_active
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   AST_OE_SEL: assert property (
      o_dout_oe |-> o_cs_active || $past(o_cs_active))
      else $error("output driven while deselected");
   AST_CS_REC: assert property (
      $rose(o_cs_active) |-> !i_cs_n && !$past(i_cs_n, 4))
      else $error("select recognised too early");
   AST_CS_DROP: assert property (
      $fell(o_cs_active) |-> i_cs_n && $past(i_cs_n, 4))
      else $error("deselect recognised too early");
   AST_START_ONE: assert property (
      o_conv_start |=> !o_conv_start && o_conv_busy)
      else $error("start pulse wrong");
   AST_START_END: assert property (
      o_conv_start |-> $past(o_dout_oe) && o_cs_active)
      else $error("start outside a transfer");
   AST_BUSY_QUIET: assert property (
      o_conv_busy |-> !o_dout_oe)
      else $error("output driven during conversion");
   AST_BUSY_END: assert property (
      $rose(o_conv_busy) |-> ##[1:300] !o_conv_busy)
      else $error("conversion never ends");
   AST_CFG_HOLD: assert property (
      o_conv_busy && $past(o_conv_busy) |->
      $stable(o_conv_mux) && $stable(o_conv_unipolar))
      else $error("config changed during conversion");
   AST_DOUT_FALL: assert property (
      o_dout_oe && $past(o_dout_oe) && $changed(o_dout) |-> !i_sclk)
      else $error("data changed with shift clock high");
endmodule // ascp_port_checker
`default_nettype wire

// ### tb/ascp_master.sv
// Partner: serial master driving select, shift clock and config.
// Assumes a 200 ns shift clock made from the 25 ns system clock.
`timescale 1ns/1ps
`default_nettype none
module ascp_master (
   input wire i_ref_clk,
   input wire i_dout,
   input wire i_dout_oe,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_din
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic xfer(input logic [7:0] cfg, input logic hold,
         output logic [15:0] got, output logic ok);
      int i;
      int n;
      n = 8 + 2 * cfg[1:0] + (cfg[1:0] == 2'h3 ? 2 : 0);
      got = 16'h0000;
      ok = 1'b0;
      o_cs_n = 1'b0;
      for (i = 0; i < 600 && !ok; i++) begin
         tick(1);
         ok = i_dout_oe;
      end
      // change on fall, sample on rise
      for (i = 0; i < n; i++) begin
         o_din = (i < 8) ? cfg[7 - i] : ~o_din;
         tick(4);
         o_sclk = 1'b1;
         got[i] = i_dout_oe ? i_dout : ~i_dout;
         tick(4);
         o_sclk = 1'b0;
      end
      o_din = ~o_din;
      if (!hold) begin
         o_cs_n = 1'b1;
         tick(30);
      end
   endtask
   // Short select glitch, clocks while deselected
   task automatic noise();
      o_cs_n = 1'b0;
      tick(3);
      o_cs_n = 1'b1;
      repeat (3) begin
         tick(4);
         o_sclk = 1'b1;
         tick(4);
         o_sclk = 1'b0;
      end
   endtask
endmodule // ascp_master
`default_nettype wire

// ### tb/ascp_port_bench.sv
// Bench: config/result transfers through the master model.
// Assumes a 260 ns conversion clock and a short conversion time.
`timescale 1ns/1ps
`default_nettype none
module ascp_port_bench;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_aclk = 1'b0;
   logic [9:0] i_conv_code = 10'h000;
   wire cs_n, sclk, din, o_dout, o_dout_oe, o_conv_start, o_conv_busy;
   wire o_conv_unipolar, o_cs_active;
   wire [3:0] o_conv_mux;
   int err_count = 0;
   int checks = 0;
   logic [7:0] cfg [9] = '{8'h55, 8'hA3, 8'h36, 8'hCA, 8'h1F, 8'hF1,
      8'h67, 8'h9B, 8'h00};
   logic [9:0] code [9] = '{10'h3FF, 10'h200, 10'h1FF, 10'h2A5, 10'h15A,
      10'h0F0, 10'h30F, 10'h0C3, 10'h0C3};
   always #12.5 i_ref_clk = ~i_ref_clk;
   always #130 i_aclk = ~i_aclk;
   ascp_port #(.CONV_ACLK(4)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .i_aclk(i_aclk),
      .i_conv_code(i_conv_code), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
      .o_conv_start(o_conv_start), .o_conv_busy(o_conv_busy),
      .o_conv_mux(o_conv_mux), .o_conv_unipolar(o_conv_unipolar),
      .o_cs_active(o_cs_active));
   ascp_master m (.i_ref_clk(i_ref_clk), .i_dout(o_dout),
      .i_dout_oe(o_dout_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [15:0] exp_word(input logic [9:0] r,
         input logic ord, input logic uni, input logic [1:0] l);
      logic [15:0] w;
      w = 16'h0000;
      for (int k = 0; k < 8 + 2 * l + (l == 2'h3 ? 2 : 0); k++)
         w[k] = ord ? (k < 10 ? r[9 - k] : 1'b0)
            : (k < 10 ? r[k] : ~uni & r[9]);
      return w;
   endfunction
   initial begin
      logic [15:0] got;
      logic ok;
      logic [9:0] r;
      logic ord;
      logic uni;
      r = 10'h000;
      ord = 1'b0;
      uni = 1'b0;
      repeat (10) @(posedge i_ref_clk);
      #1;
      i_rst = 1'b0;
      m.noise();
      m.tick(20);
      cmp({14'h0, o_cs_active, o_dout_oe}, 16'h0000);
      for (int j = 0; j < 9; j++) begin
         i_conv_code = code[j];
         m.xfer(cfg[j], j == 7, got, ok);
         cmp({15'h0, ok}, 16'h0001);
         cmp(got, exp_word(r, ord, uni, cfg[j][1:0]));
         cmp({11'h0, o_conv_mux, o_conv_unipolar}, {11'h0, cfg[j][7:3]});
         r = cfg[j][3] ? code[j] : code[j] ^ 10'h200;
         ord = cfg[j][2];
         uni = cfg[j][3];
         for (int w = 0; w < 400 && o_conv_busy !== 1'b0 && j != 7; w++)
            m.tick(1);
         if (j != 7) cmp({15'h0, o_conv_busy}, 16'h0000);
      end
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      err_count++;
      end_of_test();
   end
endmodule // ascp_port_bench
bind ascp_port ascp_port_checker chk (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_dout(o_dout),
   .o_dout_oe(o_dout_oe), .o_conv_start(o_conv_start),
   .o_conv_busy(o_conv_busy), .o_conv_mux(o_conv_mux),
   .o_conv_unipolar(o_conv_unipolar), .o_cs_active(o_cs_active));
`default_nettype wire
